/* src/cmp_pin_sel_pkg.sv */
package cmp_pin_sel_pkg;
   // Register address and data types
   typedef logic [7:0] addr_t;
   typedef logic [7:0] data_t;
   typedef logic [3:0] sel_t;
endpackage

/* src/cmp_pin_sel_regs.svh */
`ifndef CMP_PIN_SEL_REGS_SVH
`define CMP_PIN_SEL_REGS_SVH
// Register offset of the selection register (byte address)
`define COMPARATOR_PIN_SELECT_OFS 8'hEB
// Implemented selection field
`define SEL_WIDTH 4
`define SEL_RESET 4'h0
`define SEL_HI_BIT 3
`endif

/* src/comparator_input_pin_select.sv */
`timescale 1ns/1ns
`include "cmp_pin_sel_regs.svh"
module comparator_input_pin_select (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Register port
   input wire cmp_pin_sel_pkg::addr_t addr_i,
   input wire cmp_pin_sel_pkg::data_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output cmp_pin_sel_pkg::data_t rdata_o,
   // Per pin analog select, bit n for port2 pin n+4
   output cmp_pin_sel_pkg::sel_t analog_sel_o,
   // Per pin port I/O enable, bit n for port2 pin n+4
   output cmp_pin_sel_pkg::sel_t port_io_en_o
);
   // Reset release synchroniser
   logic rst_meta_reg;
   logic rst_sync_reg;
   // Selection state and outputs
   cmp_pin_sel_pkg::sel_t sel_reg, sel_next;
   cmp_pin_sel_pkg::data_t rdata_reg, rdata_next;
   cmp_pin_sel_pkg::sel_t analog_reg, analog_next;
   cmp_pin_sel_pkg::sel_t io_reg, io_next;
   logic hit;

   // Release reset through two flip-flops
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Address decode
   assign hit = (addr_i == `COMPARATOR_PIN_SELECT_OFS);

   // Next values for register, read data and pin controls
   always_comb begin
      sel_next = sel_reg;
      // Only low four bits stored; upper ignored
      if (wr_i && hit) begin
         sel_next = wdata_i[`SEL_HI_BIT:0];
      end
      // Read data; unmapped or upper bits read zero
      rdata_next = 8'h00;
      if (rd_i && hit) begin
         rdata_next = {4'h0, sel_reg};
      end
      // Pin 7 to input 3 pin 6 to input 2
      // Pins 5,4 to inputs 1,0 wins over port config
      analog_next = sel_next;
      // Clear bit leaves pin to port logic
      io_next = ~sel_next;
   end

   // Register all state
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         sel_reg <= `SEL_RESET;
         rdata_reg <= 8'h00;
         analog_reg <= `SEL_RESET;
         io_reg <= 4'hF;
      end else begin
         sel_reg <= sel_next;
         rdata_reg <= rdata_next;
         analog_reg <= analog_next;
         io_reg <= io_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign analog_sel_o = analog_reg;
   assign port_io_en_o = io_reg;

   // Write reaches pin 7 select next cycle
   pin7_route_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      wr_i && hit |=> analog_sel_o[3] == $past(wdata_i[3]))
      else $error("pin 7 route wrong");
   pin6_route_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      wr_i && hit |=> analog_sel_o[2] == $past(wdata_i[2]))
      else $error("pin 6 route wrong");
   low_pins_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      wr_i && hit |=> analog_sel_o[1:0] == $past(wdata_i[1:0]))
      else $error("pins 5/4 route wrong");
   io_excl_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      (port_io_en_o & analog_sel_o) == 4'h0
      && (port_io_en_o | analog_sel_o) == 4'hF)
      else $error("pin both or neither");
   sel_hold_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      !(wr_i && hit) |=> $stable(analog_sel_o))
      else $error("select changed without write");
   read_back_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      rd_i && hit |=> rdata_o == {4'h0, $past(sel_reg)})
      else $error("read back wrong");
   idle_read_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      !(rd_i && hit) |=> rdata_o == 8'h00)
      else $error("idle read not zero");
   write_read_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_sync_reg)
      wr_i && hit ##1 rd_i && hit |=>
      rdata_o[3:0] == $past(wdata_i[3:0], 2))
      else $error("write then read wrong");
endmodule

/* testbench/comparator_input_pin_select_tb.sv */
`timescale 1ns/1ns
`include "cmp_pin_sel_regs.svh"
module comparator_input_pin_select_tb;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, rd_q = 0;
   cmp_pin_sel_pkg::addr_t addr = 8'h00;
   cmp_pin_sel_pkg::data_t wd = 8'h00, rdata;
   cmp_pin_sel_pkg::sel_t sel, io_en, routed, shadow = 4'h0;
   logic [15:0] exp_q[$];
   int n_mismatch = 0, checked = 0;
   comparator_input_pin_select dut (.sys_clk_i(clk), .resetn_i(rstn),
      .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .analog_sel_o(sel), .port_io_en_o(io_en));
   pin_side_model far (.analog_sel_i(sel), .port_io_en_i(io_en),
      .routed_o(routed));
   // Clock
   initial forever #5 clk = ~clk;
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("ERROR regs expected %h seen %h", want, seen);
      end
   endtask
   // Verdict
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Write then read back at once, noting the expected answer
   task automatic acc(input logic [7:0] a, input logic [7:0] d);
      logic hit;
      hit = (a == `COMPARATOR_PIN_SELECT_OFS);
      if (hit) shadow = d[3:0];
      exp_q.push_back({hit ? {4'h0, shadow} : 8'h00, shadow, ~shadow});
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // Watcher: read data, routing and port enables
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd_q) check({rdata, routed, io_en}, exp_q.pop_front());
   end
   // Main sequence
   initial begin
      void'($urandom(81949));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      acc(8'h00, 8'hFF);
      for (int i = 0; i < 16; i++) begin
         acc(`COMPARATOR_PIN_SELECT_OFS, {4'($urandom), 4'(i)});
      end
      repeat (30) acc(8'hEA + 8'($urandom_range(0, 3)), 8'($urandom));
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule

/* testbench/pin_side_model.sv */
`timescale 1ns/1ns
module pin_side_model (
   // Select lines from the block
   input wire cmp_pin_sel_pkg::sel_t analog_sel_i,
   input wire cmp_pin_sel_pkg::sel_t port_io_en_i,
   // Pins that reach the comparator
   output cmp_pin_sel_pkg::sel_t routed_o
);
   // Port side lets a pin go only when its I/O is off
   assign routed_o = analog_sel_i & ~port_io_en_i;
endmodule
